// File: logic/serial_port.v
/*
 Enhanced asynchronous serial port: shift-register mode, 8-bit and 9-bit
 asynchronous modes, timer or divider baud sources, framing error, break
 detect with break reset request, and transmit double buffering.
 Assumes the processor drives the control bits as plain levels and issues
 one-cycle write strobes; all inputs are synchronous to core_clk.
*/
//
// Operation
// - Mode 0 shifts eight bits LSB first on rx pin, clock on tx while sending, clk/16.
// - Mode 1 frame: low start, eight data bits LSB first, high stop.
// - Mode 1 reception stores the stop bit in the receive ninth bit.
// - Mode 1 rate comes from timer 1 overflow or the baud divider.
// - Mode 2 frame adds the transmit ninth bit before the stop bit.
// - Mode 2 reception stores the ninth bit and drops the stop bit.
// - Mode 2 rate is clock/16 or clock/32 by the baud double bit.
// - Mode 3 equals mode 2 but uses timer 1 or the divider rate.
// - Divider takes a 16-bit divisor from high and low bytes.
// - The baud divider runs from the core clock.
// - Timer 1 overflow is halved further when baud double is clear.
// - Sources are fixed clock division, timer 1 or divider only.
// - Framing error flagged in status; control bit 7 overlays it.
// - Eleven low bit times on receive line flag a break.
// - A break may reset the device into the boot flow.
// - Buffered character follows the current one after one stop bit.
// - With double buffering off, transmit is single buffered.
// - In async modes, buffered transmit flag rises when the buffer accepts more data.
// - Buffered ninth bit is latched together with the data byte.
// - After break reset, fetch starts at boot vector high, zero low.
// - Break reset sets a sticky source flag cleared by writing zero.
`timescale 1ns/10ps
`include "uart_map.vh"
module serial_port #(
   parameter FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire core_clk,
   input wire sys_rst,
   input wire clk_en,
   input wire power_on_rst,
   input wire mode_select_bit0,
   input wire mode_select_bit1,
   input wire rx_enable,
   input wire tx_ninth_bit,
   input wire baud_double_bit,
   input wire framing_overlay_bit,
   input wire double_buffer_enable,
   input wire baud_src_sel,
   input wire timer1_overflow,
   input wire [7:0] baud_divisor_high,
   input wire [7:0] baud_divisor_low,
   input wire break_reset_enable,
   input wire [7:0] boot_vector,
   input wire [7:0] tx_data,
   input wire tx_write,
   output wire tx_ready,
   input wire ri_clear,
   input wire ti_clear,
   input wire status_clear,
   input wire break_src_clear,
   output reg [7:0] serial_data_buffer,
   output reg rx_ninth_bit,
   output reg rx_flag,
   output reg tx_flag,
   output wire ctrl_bit7,
   output reg framing_error,
   output reg break_detect,
   output reg break_reset_req,
   output reg break_reset_src,
   output wire [15:0] boot_address,
   input wire rxd_in,
   output reg rxd_out,
   output reg rxd_oe_n,
   output reg txd_out
);
   localparam ST_IDLE = 2'h0;
   localparam ST_START = 2'h1;
   localparam ST_BITS = 2'h2;

   wire [1:0] mode = {mode_select_bit0, mode_select_bit1};
   wire async_mode = (mode != `MODE_SHIFT);
   wire nine_bit = mode[1];
   wire var_rate = (mode == `MODE_8BIT) || (mode == `MODE_9BIT_VAR);

   // Baud tick generation, one tick per sixteenth of a bit time.
   reg [15:0] div_cnt_reg;
   reg t1_half_reg;
   reg [4:0] fix_cnt_reg;
   reg var_tick;
   reg fix_tick;
   wire [15:0] divisor = {baud_divisor_high, baud_divisor_low};

   function [4:0] fixed_limit;
      input dbl;
      integer lim;
      begin
         lim = dbl ? `FIXED_DIV_FAST / `OVERSAMPLE - 1 : `FIXED_DIV_SLOW / `OVERSAMPLE - 1;
         fixed_limit = lim[4:0];
      end
   endfunction

   always @(posedge core_clk) begin
      if (sys_rst) begin
         div_cnt_reg <= 16'h0000;
         t1_half_reg <= 1'b0;
         fix_cnt_reg <= 5'h00;
      end else if (clk_en) begin
         if (div_cnt_reg >= divisor) begin
            div_cnt_reg <= 16'h0000;
         end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
         end
         if (timer1_overflow) begin
            t1_half_reg <= ~t1_half_reg;
         end
         if (fix_cnt_reg >= fixed_limit(baud_double_bit)) begin
            fix_cnt_reg <= 5'h00;
         end else begin
            fix_cnt_reg <= fix_cnt_reg + 5'h01;
         end
      end
   end

   always @* begin
      if (baud_src_sel == `SRC_DIVIDER) begin
         var_tick = (div_cnt_reg >= divisor);
      end else begin
         var_tick = timer1_overflow && (baud_double_bit || t1_half_reg);
      end
      fix_tick = (fix_cnt_reg >= fixed_limit(baud_double_bit));
   end

   // rate per mode; mode 0 runs every core clock.
   wire tick = (mode == `MODE_SHIFT) ? 1'b1 : (var_rate ? var_tick : fix_tick);

   // Transmit holding buffer; depth 1 in effect without double buffering.
   wire fifo_in_ready;
   wire [8:0] fifo_out_data;
   wire fifo_out_valid;
   reg fifo_pop;
   reg tx_busy_reg;
   // single buffering refuses writes while shifting
   assign tx_ready = double_buffer_enable ? fifo_in_ready : (!tx_busy_reg && !fifo_out_valid);

   tx_fifo #(
      .WIDTH(9),
      .DEPTH(FIFO_DEPTH),
      .AW(3)
   ) u_tx_fifo (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      // ninth bit latched with data when buffered
      .in_data({tx_ninth_bit, tx_data}),
      .in_valid(tx_write && tx_ready),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop)
   );

   // Transmitter.
   reg [1:0] tx_state_reg;
   reg [3:0] tx_sub_reg;
   reg [3:0] tx_bit_reg;
   reg [9:0] tx_shift_reg;
   reg [3:0] tx_last;
   always @* begin
      // stop bit index after the start bit
      tx_last = nine_bit ? 4'h9 : 4'h8;
      fifo_pop = clk_en && fifo_out_valid && !tx_busy_reg;
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         tx_state_reg <= ST_IDLE;
         tx_sub_reg <= 4'h0;
         tx_bit_reg <= 4'h0;
         tx_shift_reg <= 10'h3ff;
         tx_busy_reg <= 1'b0;
         txd_out <= 1'b1;
         tx_flag <= 1'b0;
      end else if (clk_en) begin
         if (ti_clear) begin
            tx_flag <= 1'b0;
         end
         // buffered flag on space in the holding buffer
         if (double_buffer_enable && tx_write && fifo_in_ready && async_mode) begin
            tx_flag <= 1'b1;
         end
         case (tx_state_reg)
            ST_IDLE: begin
               txd_out <= 1'b1;
               if (fifo_pop) begin
                  tx_busy_reg <= 1'b1;
                  tx_sub_reg <= 4'h0;
                  tx_bit_reg <= 4'h0;
                  if (async_mode) begin
                     // ninth bit taken from the control flag or the buffer
                     tx_shift_reg <= {1'b1, (double_buffer_enable ? fifo_out_data[8] :
                        tx_ninth_bit), fifo_out_data[7:0]};
                     tx_state_reg <= ST_START;
                  end else begin
                     tx_shift_reg <= {2'h3, fifo_out_data[7:0]};
                     tx_state_reg <= ST_BITS;
                  end
               end
            end
            ST_START: begin
               txd_out <= 1'b0;
               if (tick) begin
                  tx_sub_reg <= tx_sub_reg + 4'h1;
                  if (tx_sub_reg == 4'hf) begin
                     tx_state_reg <= ST_BITS;
                  end
               end
            end
            ST_BITS: begin
               if (tick) begin
                  tx_sub_reg <= tx_sub_reg + 4'h1;
               end
               if (!async_mode) begin
                  // shift clock low for the first half of each bit
                  txd_out <= tx_sub_reg[3];
               end else if (tx_bit_reg == tx_last) begin
                  txd_out <= 1'b1;
               end else begin
                  txd_out <= tx_shift_reg[tx_bit_reg];
               end
               if (tick && tx_sub_reg == 4'hf) begin
                  tx_bit_reg <= tx_bit_reg + 4'h1;
                  if (tx_bit_reg == (async_mode ? tx_last : 4'h7)) begin
                     // next buffered frame starts straight after one stop bit
                     tx_busy_reg <= 1'b0;
                     tx_state_reg <= ST_IDLE;
                     if (!double_buffer_enable) begin
                        tx_flag <= 1'b1;
                     end
                  end
               end
            end
            default: begin
               tx_state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Receive line drive in mode 0: data out on the rx pin while sending.
   always @(posedge core_clk) begin
      if (sys_rst) begin
         rxd_out <= 1'b1;
         rxd_oe_n <= 1'b1;
      end else if (clk_en) begin
         // two-way data on the receive pin
         rxd_oe_n <= !(!async_mode && tx_busy_reg);
         rxd_out <= (tx_bit_reg < 4'h8) ? tx_shift_reg[tx_bit_reg[2:0]] : 1'b1;
      end
   end

   // Receiver, sampling mid-bit on the sixteenth ticks.
   reg [1:0] rx_state_reg;
   reg [3:0] rx_sub_reg;
   reg [3:0] rx_bit_reg;
   reg [8:0] rx_shift_reg;
   reg [7:0] low_bits_reg;
   reg [3:0] low_sub_reg;
   wire shift_rx = !async_mode && rx_enable && !tx_busy_reg && !fifo_out_valid;

   always @(posedge core_clk) begin
      if (sys_rst) begin
         rx_state_reg <= ST_IDLE;
         rx_sub_reg <= 4'h0;
         rx_bit_reg <= 4'h0;
         rx_shift_reg <= 9'h000;
         serial_data_buffer <= 8'h00;
         rx_ninth_bit <= 1'b0;
         rx_flag <= 1'b0;
         framing_error <= 1'b0;
      end else if (clk_en) begin
         if (ri_clear) begin
            rx_flag <= 1'b0;
         end
         if (status_clear) begin
            framing_error <= 1'b0;
         end
         case (rx_state_reg)
            ST_IDLE: begin
               rx_sub_reg <= 4'h0;
               rx_bit_reg <= 4'h0;
               if (async_mode && rx_enable && !rxd_in) begin
                  rx_state_reg <= ST_START;
               end else if (shift_rx && !rx_flag) begin
                  rx_state_reg <= ST_BITS;
               end
            end
            ST_START: begin
               if (tick) begin
                  rx_sub_reg <= rx_sub_reg + 4'h1;
                  if (rx_sub_reg == 4'h7) begin
                     // A start bit that is gone by mid-bit was noise.
                     rx_state_reg <= rxd_in ? ST_IDLE : ST_BITS;
                     rx_sub_reg <= 4'h0;
                  end
               end
            end
            ST_BITS: begin
               if (tick) begin
                  rx_sub_reg <= rx_sub_reg + 4'h1;
                  if (rx_sub_reg == 4'hf) begin
                     rx_bit_reg <= rx_bit_reg + 4'h1;
                     rx_shift_reg <= {rxd_in, rx_shift_reg[8:1]};
                     if (!async_mode && rx_bit_reg == 4'h7) begin
                        serial_data_buffer <= {rxd_in, rx_shift_reg[8:2]};
                        rx_flag <= 1'b1;
                        rx_state_reg <= ST_IDLE;
                     end else if (async_mode && rx_bit_reg == tx_last) begin
                        // load buffer and flag at stop bit
                        rx_state_reg <= ST_IDLE;
                        rx_flag <= 1'b1;
                        // stop bit low is a framing error
                        if (!rxd_in) begin
                           framing_error <= 1'b1;
                        end
                        if (nine_bit) begin
                           serial_data_buffer <= rx_shift_reg[7:0];
                           rx_ninth_bit <= rx_shift_reg[8];
                        end else begin
                           // stop bit into receive ninth bit
                           serial_data_buffer <= rx_shift_reg[8:1];
                           rx_ninth_bit <= rxd_in;
                        end
                     end
                  end
               end
            end
            default: begin
               rx_state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // bit 7 of the control byte reads framing error or mode bit
   assign ctrl_bit7 = framing_overlay_bit ? framing_error : mode_select_bit0;

   // Break detector counts whole low bit times independent of framing.
   always @(posedge core_clk) begin
      if (sys_rst) begin
         low_bits_reg <= 8'h00;
         low_sub_reg <= 4'h0;
         break_detect <= 1'b0;
         break_reset_req <= 1'b0;
      end else if (clk_en) begin
         break_reset_req <= 1'b0;
         if (status_clear) begin
            break_detect <= 1'b0;
         end
         if (rxd_in || !async_mode) begin
            low_bits_reg <= 8'h00;
            low_sub_reg <= 4'h0;
         end else if (tick) begin
            low_sub_reg <= low_sub_reg + 4'h1;
            if (low_sub_reg == 4'hf && low_bits_reg < `BREAK_BITS) begin
               low_bits_reg <= low_bits_reg + 8'h01;
               if (low_bits_reg == `BREAK_BITS - 1) begin
                  break_detect <= 1'b1;
                  break_reset_req <= break_reset_enable;
               end
            end
         end
      end
   end

   // Reset source flag lives outside sys_rst so it survives the reset it causes.
   always @(posedge core_clk) begin
      if (power_on_rst) begin
         break_reset_src <= 1'b0;
      end else if (clk_en) begin
         // sticky flag, set wins over clear
         if (break_reset_req) begin
            break_reset_src <= 1'b1;
         end else if (break_src_clear) begin
            break_reset_src <= 1'b0;
         end
      end
   end

   // boot fetch address after a break reset
   assign boot_address = break_reset_src ? {boot_vector, `BOOT_LOW} : 16'h0000;
endmodule

// File: logic/tx_fifo.v
/*
 Parameterised synchronous FIFO with valid/ready on both sides.
 Assumes one clock with clock enable and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module tx_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire core_clk,
   input wire sys_rst,
   input wire clk_en,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output reg [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;

   assign in_ready = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @* begin
      out_data = mem[rd_ptr_reg];
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else if (clk_en) begin
         if (push) begin
            mem[wr_ptr_reg] <= in_data;
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

// File: logic/uart_map.vh
/*
 Shared constants of the enhanced serial port: mode codes, bit positions of the
 control and status bytes, baud source codes and reset values.
 Included by the serial port only; its transmit FIFO takes the depth as a parameter; defines only.
*/
`ifndef UART_MAP_VH
`define UART_MAP_VH

`define MODE_SHIFT 2'h0
`define MODE_8BIT 2'h1
`define MODE_9BIT_FIXED 2'h2
`define MODE_9BIT_VAR 2'h3

`define SRC_TIMER1 1'h0
`define SRC_DIVIDER 1'h1

`define CTRL_RI 0
`define CTRL_TI 1
`define CTRL_RB8 2
`define CTRL_TB8 3
`define CTRL_REN 4
`define CTRL_SM1 6
`define CTRL_SM0_FE 7

`define STAT_BREAK 0
`define STAT_FE 1
`define STAT_DB 7

`define SHIFT_DIV 16
`define FIXED_DIV_FAST 16
`define FIXED_DIV_SLOW 32
`define OVERSAMPLE 16
`define BREAK_BITS 11
`define BOOT_LOW 8'h00
`define FIFO_DEPTH 8

`endif

// File: tb/enhanced_uart_with_baud_generator_test.sv
/*
 Self-checking bench for the enhanced serial port with its remote partner.
 Assumes a 50 MHz core clock; inputs change 2 ns after each rising edge.
*/
`timescale 1ns/10ps
module enhanced_uart_with_baud_generator_test;
   logic core_clk, sys_rst, power_on_rst, mode_select_bit0, mode_select_bit1, rx_enable;
   logic tx_ninth_bit, baud_double_bit, framing_overlay_bit, double_buffer_enable;
   logic baud_src_sel, timer1_overflow, break_reset_enable, tx_write, ri_clear, ti_clear;
   logic status_clear, break_src_clear, prev;
   logic [7:0] baud_divisor_high, baud_divisor_low, boot_vector, tx_data, v;
   logic [10:0] got;
   wire [7:0] serial_data_buffer;
   wire [15:0] boot_address;
   wire tx_ready, rx_ninth_bit, rx_flag, tx_flag, ctrl_bit7, framing_error, break_detect;
   wire break_reset_req, break_reset_src, rxd_in, rxd_out, rxd_oe_n, txd_out;
   int fails, compares, gap, k, j, n, first, last;

   serial_port #(.FIFO_DEPTH(8)) uut (
      .core_clk, .sys_rst, .clk_en(1'b1), .power_on_rst, .mode_select_bit0,
      .mode_select_bit1, .rx_enable, .tx_ninth_bit, .baud_double_bit, .framing_overlay_bit,
      .double_buffer_enable, .baud_src_sel, .timer1_overflow, .baud_divisor_high,
      .baud_divisor_low, .break_reset_enable, .boot_vector, .tx_data, .tx_write, .tx_ready,
      .ri_clear, .ti_clear, .status_clear, .break_src_clear, .serial_data_buffer,
      .rx_ninth_bit, .rx_flag, .tx_flag, .ctrl_bit7, .framing_error, .break_detect,
      .break_reset_req, .break_reset_src, .boot_address, .rxd_in, .rxd_out, .rxd_oe_n,
      .txd_out
   );
   remote_uart peer (.core_clk(core_clk), .line_in(txd_out), .line_out(rxd_in));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Overflow pulses every second clock, so the timer tick is two clocks with baud double set, four with it clear.
   initial begin
      timer1_overflow = 1'b0;
      forever begin
         @(posedge core_clk);
         #2 timer1_overflow = ~timer1_overflow;
      end
   end

   task automatic give_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge core_clk);
      #2;
   endtask
   task automatic bound(input int c, input int lim);
      if (c >= lim) begin
         fails++;
         give_verdict();
      end
   endtask
   task automatic put(input logic [7:0] d);
      int w;
      for (w = 0; w < 5000 && tx_ready !== 1'b1; w++) step(1);
      bound(w, 5000);
      tx_data = d;
      tx_write = 1'b1;
      step(1);
      tx_write = 1'b0;
   endtask
   // Mode is only changed while the transmitter is idle.
   task automatic cfg(input logic [1:0] m, input logic src, input logic bd, input logic [15:0] div);
      {mode_select_bit0, mode_select_bit1} = m;
      baud_src_sel = src;
      baud_double_bit = bd;
      {baud_divisor_high, baud_divisor_low} = div;
      step(2);
   endtask
   task automatic run_tx(input logic [1:0] m, input logic src, input logic bd,
         input logic [15:0] div, input int bc, input logic [7:0] d, input logic n9);
      cfg(m, src, bd, div);
      tx_ninth_bit = n9;
      put(d);
      peer.grab(m[1] ? 11 : 10, bc, got, gap);
      bound(gap, 5000);
      check({5'h0, got}, {5'h0, 1'b1, m[1] ? n9 : 1'b1, d, 1'b0});
      step(bc);
   endtask
   task automatic rx_case(input logic [10:0] bits, input int nb, input logic [15:0] exp);
      int w;
      {ri_clear, status_clear} = 2'b11;
      step(1);
      {ri_clear, status_clear} = 2'b00;
      peer.send(bits, nb, 16);
      for (w = 0; w < 200 && rx_flag !== 1'b1; w++) step(1);
      bound(w, 200);
      check({6'h0, framing_error, rx_ninth_bit, serial_data_buffer}, exp);
   endtask

   initial begin
      {mode_select_bit0, mode_select_bit1, rx_enable, tx_ninth_bit, baud_double_bit} = '0;
      {framing_overlay_bit, double_buffer_enable, break_reset_enable, tx_write} = '0;
      {ri_clear, ti_clear, status_clear, break_src_clear} = '0;
      {baud_divisor_high, baud_divisor_low, tx_data} = '0;
      baud_src_sel = 1'b1;
      boot_vector = 8'h5a;
      fails = 0;
      compares = 0;
      sys_rst = 1'b1;
      power_on_rst = 1'b1;
      step(4);
      sys_rst = 1'b0;
      power_on_rst = 1'b0;
      step(1);
      check({serial_data_buffer, txd_out, rxd_oe_n, rxd_out, rx_flag, tx_flag, framing_error,
         break_detect, break_reset_src}, 16'h00e0);
      run_tx(2'b01, 1'b1, 1'b0, 16'h0000, 16, 8'ha5, 1'b0);
      run_tx(2'b01, 1'b1, 1'b0, 16'h0001, 32, 8'h3c, 1'b0);
      run_tx(2'b01, 1'b0, 1'b1, 16'h0000, 32, 8'h5a, 1'b0);
      run_tx(2'b01, 1'b0, 1'b0, 16'h0000, 64, 8'hc3, 1'b0);
      run_tx(2'b10, 1'b1, 1'b1, 16'h0000, 16, 8'h81, 1'b1);
      run_tx(2'b10, 1'b1, 1'b0, 16'h0000, 32, 8'h18, 1'b0);
      run_tx(2'b11, 1'b1, 1'b0, 16'h0000, 16, 8'he7, 1'b1);
      cfg(2'b01, 1'b1, 1'b0, 16'h0000);
      put(8'h0f);
      step(2);
      check({15'h0, tx_ready}, 16'h0000);
      tx_data = 8'hf0;
      tx_write = 1'b1;
      step(1);
      tx_write = 1'b0;
      peer.grab(10, 16, got, gap);
      check({5'h0, got}, {5'h0, 1'b1, 1'b1, 8'h0f, 1'b0});
      step(24);
      check({14'h0, tx_ready, txd_out}, 16'h0003);
      // Fill the buffer back to back until it refuses, then drain it.
      double_buffer_enable = 1'b1;
      cfg(2'b11, 1'b1, 1'b0, 16'h0000);
      ti_clear = 1'b1;
      step(1);
      ti_clear = 1'b0;
      fork
         peer.grab(11, 16, got, gap);
      join_none
      for (k = 0; k < 12 && tx_ready === 1'b1; k++) begin
         tx_ninth_bit = k[0];
         tx_data = 8'h40 + k[7:0];
         tx_write = 1'b1;
         step(1);
      end
      tx_write = 1'b0;
      check(k[15:0], 16'h0009);
      check({15'h0, tx_flag}, 16'h0001);
      wait fork;
      for (j = 0; j < 9; j++) begin
         if (j > 0) peer.grab(11, 16, got, gap);
         check({5'h0, got}, {5'h0, 1'b1, j[0], 8'h40 + j[7:0], 1'b0});
         if (j > 0) check({15'h0, gap >= 5 && gap <= 11}, 16'h0001);
      end
      step(16);
      check({15'h0, tx_ready}, 16'h0001);
      double_buffer_enable = 1'b0;
      rx_enable = 1'b1;
      cfg(2'b01, 1'b1, 1'b0, 16'h0000);
      rx_case({2'b11, 8'h3c, 1'b0}, 10, 16'h013c);
      cfg(2'b11, 1'b1, 1'b0, 16'h0000);
      rx_case({1'b0, 1'b1, 8'hc3, 1'b0}, 11, 16'h03c3);
      framing_overlay_bit = 1'b1;
      step(1);
      check({15'h0, ctrl_bit7}, 16'h0001);
      status_clear = 1'b1;
      step(1);
      status_clear = 1'b0;
      step(1);
      check({15'h0, ctrl_bit7}, 16'h0000);
      framing_overlay_bit = 1'b0;
      cfg(2'b01, 1'b1, 1'b0, 16'h0000);
      break_reset_enable = 1'b1;
      peer.send(11'h000, 11, 24);
      for (k = 0; k < 300 && break_detect !== 1'b1; k++) step(1);
      bound(k, 300);
      check({14'h0, break_detect, break_reset_src}, 16'h0003);
      check(boot_address, 16'h5a00);
      sys_rst = 1'b1;
      step(1);
      sys_rst = 1'b0;
      step(1);
      check({15'h0, break_reset_src}, 16'h0001);
      break_src_clear = 1'b1;
      step(1);
      break_src_clear = 1'b0;
      step(1);
      check({15'h0, break_reset_src}, 16'h0000);
      check(boot_address, 16'h0000);
      rx_enable = 1'b0;
      cfg(2'b00, 1'b1, 1'b0, 16'h0000);
      put(8'h96);
      n = 0;
      prev = txd_out;
      for (k = 0; k < 400 && n < 8; k++) begin
         @(negedge core_clk);
         if (txd_out === 1'b1 && prev === 1'b0) begin
            if (n == 0) first = k;
            v = {rxd_out, v[7:1]};
            n++;
            last = k;
         end
         prev = txd_out;
      end
      bound(k, 400);
      check({7'h0, rxd_oe_n, v}, 16'h0096);
      check(last[15:0] - first[15:0], 16'h0070);
      step(40);
      give_verdict();
   end
endmodule

// File: tb/remote_uart.sv
/*
 Remote serial transceiver: sends frames on the port's receive line and
 captures frames from its transmit line. Bit length is given in core clocks.
*/
`timescale 1ns/10ps
module remote_uart (
   input wire core_clk,
   input wire line_in,
   output logic line_out
);
   initial line_out = 1'b1;
   task automatic send(input logic [10:0] bits, input int n, input int bc);
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         #2 line_out = bits[i];
         repeat (bc - 1) @(posedge core_clk);
      end
      @(posedge core_clk);
      #2 line_out = 1'b1;
   endtask
   // Samples each bit mid-cell; gap is the wait for the start bit, 5000 if none came.
   task automatic grab(input int n, input int bc, output logic [10:0] bits, output int gap);
      bits = 11'h7ff;
      gap = 0;
      while (line_in !== 1'b0 && gap < 5000) begin
         @(negedge core_clk);
         gap++;
      end
      repeat (bc / 2) @(negedge core_clk);
      bits[0] = line_in;
      for (int i = 1; i < n; i++) begin
         repeat (bc) @(negedge core_clk);
         bits[i] = line_in;
      end
   endtask
endmodule

// File: tb/serial_port_chk.sv
/*
 Concurrent checks on the serial port pins, bound into every serial_port.
 Assumes the single core clock and the synchronous active-high reset.
*/
`timescale 1ns/10ps
module serial_port_chk (
   input wire core_clk,
   input wire sys_rst,
   input wire mode_select_bit0,
   input wire mode_select_bit1,
   input wire framing_overlay_bit,
   input wire double_buffer_enable,
   input wire break_reset_enable,
   input wire [7:0] boot_vector,
   input wire tx_write,
   input wire tx_ready,
   input wire ri_clear,
   input wire ti_clear,
   input wire rx_flag,
   input wire tx_flag,
   input wire ctrl_bit7,
   input wire framing_error,
   input wire break_reset_req,
   input wire break_reset_src,
   input wire [15:0] boot_address,
   input wire rxd_oe_n,
   input wire txd_out
);
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_req_pulse;
      break_reset_req ##1 !break_reset_req;
   endsequence
   a_overlay_mux: assert property (
      ctrl_bit7 == (framing_overlay_bit ? framing_error : mode_select_bit0))
      else $error("control bit 7 overlay wrong");
   a_boot_addr: assert property (
      boot_address == (break_reset_src ? {boot_vector, 8'h00} : 16'h0000))
      else $error("boot address wrong");
   a_src_sticky: assert property (break_reset_req |-> ##[0:2] break_reset_src)
      else $error("break reset source flag not set");
   a_req_pulse: assert property (break_reset_req |-> s_req_pulse)
      else $error("break reset request longer than one cycle");
   a_req_enable: assert property (break_reset_req |-> break_reset_enable)
      else $error("break reset request while disabled");
   a_single_buf: assert property (
      !double_buffer_enable && (mode_select_bit0 || mode_select_bit1) && !txd_out |-> !tx_ready)
      else $error("single buffered port ready while shifting");
   a_shift_only: assert property (
      !rxd_oe_n |-> !mode_select_bit0 && !mode_select_bit1)
      else $error("receive pin driven outside shift mode");
   a_rx_fall: assert property (
      $fell(rx_flag) |-> $past(ri_clear) || $past(sys_rst))
      else $error("receive flag dropped without clear");
   a_tx_fall: assert property (
      $fell(tx_flag) |-> $past(ti_clear) || $past(sys_rst))
      else $error("transmit flag dropped without clear");
   a_db_flag: assert property (
      double_buffer_enable && tx_write && tx_ready |-> ##[1:2] tx_flag)
      else $error("buffered write did not raise transmit flag");
endmodule

bind serial_port serial_port_chk chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .mode_select_bit0(mode_select_bit0),
   .mode_select_bit1(mode_select_bit1), .framing_overlay_bit(framing_overlay_bit),
   .double_buffer_enable(double_buffer_enable), .break_reset_enable(break_reset_enable),
   .boot_vector(boot_vector), .tx_write(tx_write), .tx_ready(tx_ready),
   .ri_clear(ri_clear), .ti_clear(ti_clear), .rx_flag(rx_flag), .tx_flag(tx_flag),
   .ctrl_bit7(ctrl_bit7), .framing_error(framing_error), .break_reset_req(break_reset_req),
   .break_reset_src(break_reset_src), .boot_address(boot_address), .rxd_oe_n(rxd_oe_n),
   .txd_out(txd_out)
);
